//--- ttf_pkg.sv
// constants for the trace capture and trigger unit
// assumes a word-addressed avalon-mm slave port and one 125 mhz clock
package ttf_pkg;
    // datapath widths
    localparam int ADDR_W   = 24;
    localparam int DATA_W   = 16;
    localparam int NUM_SETS = 4;
    localparam int NUM_TRIG = 3;
    localparam int FILT_SET = 3;
    localparam int NUM_ENT  = 50;
    localparam int ENT_W    = 6;
    localparam int BUS_AW   = 8;
    localparam int BUS_DW   = 32;
    localparam int BE_W     = 4;
    localparam int MHZ_W    = 10;
    localparam int DIV_W    = 20;
    localparam int TIME_W   = 48;
    localparam int TAG_W    = 4;
    localparam int CTRL_W   = 8;
    localparam int QSEL_W   = 10;
    localparam int SRC_W    = 2;
    // register word offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h01;
    localparam logic [7:0] REG_QSEL   = 8'h02;
    localparam logic [7:0] REG_QLO    = 8'h03;
    localparam logic [7:0] REG_QHI    = 8'h04;
    localparam logic [7:0] REG_CLK    = 8'h05;
    localparam logic [7:0] REG_PERIOD = 8'h06;
    localparam logic [3:0] SET_PAGE   = 4'h1;
    localparam logic [1:0] FLD_AMASK  = 2'h0;
    localparam logic [1:0] FLD_DMASK  = 2'h1;
    localparam logic [1:0] FLD_CNT    = 2'h2;
    // field positions
    localparam int CB_TRACE = 0;
    localparam int CB_BREAK = 1;
    localparam int CB_STOP  = 2;
    localparam int CB_FILT  = 3;
    localparam int CB_WIN   = 4;
    localparam int CB_TEN   = 5;
    localparam int QS_ENT   = 0;
    localparam int QS_LIST  = 6;
    localparam int QS_SET   = 8;
    localparam int CNT_D    = 16;
    localparam int ST_HALT  = 0;
    localparam int ST_REC   = 1;
    localparam int ST_WIN   = 2;
    localparam int ST_DIV   = 3;
    // cycle kinds, sizes, sources, tags
    localparam logic [1:0] KIND_FETCH = 2'h0;
    localparam logic [1:0] KIND_READ  = 2'h1;
    localparam logic [1:0] KIND_WRITE = 2'h2;
    localparam logic [1:0] KIND_FLUSH = 2'h3;
    localparam logic [1:0] SIZE_1     = 2'h1;
    localparam logic [1:0] SIZE_2     = 2'h2;
    localparam logic [1:0] SRC_EXTERNAL_DATA_BUS    = 2'h0;
    localparam logic [1:0] SRC_INTERNAL_INSTR_BUS   = 2'h1;
    localparam logic [1:0] SRC_INTERNAL_OPERAND_BUS = 2'h2;
    localparam logic [3:0] ONE_BYTE_WRITE_TAG = 4'h9;
    localparam logic [3:0] TWO_BYTE_FETCH_TAG = 4'h2;
    // timestamp period divider
    localparam logic [DIV_W-1:0] PS_PER_US  = 20'hf4240;
    localparam logic [MHZ_W-1:0] DEF_MHZ    = 10'h014;
    localparam logic [DIV_W-1:0] DEF_PERIOD = 20'h0c350;
    localparam logic [4:0]       DIV_LAST   = 5'h13;
    localparam logic [ENT_W-1:0] ENT_MAX    = 6'h32;
    localparam logic [BUS_DW-1:0] RD_NONE   = 32'h0;
    typedef enum logic {DIV_IDLE, DIV_RUN} ttf_div_type;
endpackage

//--- ttf_trace_unit.sv
// trace capture, trigger and filter unit of the emulator
// assumes bus-cycle inputs already decoded and synchronous to clk_i
//
// Implementation choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module ttf_trace_unit (
    input  wire logic                         clk_i,
    input  wire logic                         rst_b_i,
    input  wire logic [ttf_pkg::BUS_AW-1:0]   address_i,
    input  wire logic                         read_i,
    input  wire logic                         write_i,
    input  wire logic [ttf_pkg::BUS_DW-1:0]   writedata_i,
    input  wire logic [ttf_pkg::BE_W-1:0]     byteenable_i,
    output logic      [ttf_pkg::BUS_DW-1:0]   readdata_o,
    output logic                              waitrequest_o,
    input  wire logic                         cpu_tick_i,
    input  wire logic                         cyc_valid_i,
    input  wire logic                         cyc_exec_i,
    input  wire logic [ttf_pkg::SRC_W-1:0]    cyc_src_i,
    input  wire logic [1:0]                   cyc_kind_i,
    input  wire logic [1:0]                   cyc_size_i,
    input  wire logic [ttf_pkg::ADDR_W-1:0]   cyc_addr_i,
    input  wire logic [ttf_pkg::DATA_W-1:0]   cyc_data_i,
    output logic                              halt_o,
    output logic                              recording_o,
    output logic                              shadow_en_o,
    output logic                              frame_valid_o,
    output logic      [ttf_pkg::ADDR_W-1:0]   frame_addr_o,
    output logic      [ttf_pkg::DATA_W-1:0]   frame_data_o,
    output logic      [ttf_pkg::TAG_W-1:0]    frame_tag_o,
    output logic      [ttf_pkg::SRC_W-1:0]    frame_src_o,
    output logic      [ttf_pkg::TIME_W-1:0]   frame_time_o
);
    import ttf_pkg::*;

    typedef struct packed {
        logic                                     wreq;
        logic [BUS_DW-1:0]                        rdata;
        logic [CTRL_W-1:0]                        ctrl;
        logic [QSEL_W-1:0]                        qsel;
        logic [NUM_SETS-1:0][NUM_ENT-1:0][ADDR_W-1:0] alo;
        logic [NUM_SETS-1:0][NUM_ENT-1:0][ADDR_W-1:0] ahi;
        logic [NUM_SETS-1:0][NUM_ENT-1:0][DATA_W-1:0] dlo;
        logic [NUM_SETS-1:0][NUM_ENT-1:0][DATA_W-1:0] dhi;
        logic [NUM_SETS-1:0][ADDR_W-1:0]          amask;
        logic [NUM_SETS-1:0][DATA_W-1:0]          dmask;
        logic [NUM_SETS-1:0][ENT_W-1:0]           acnt;
        logic [NUM_SETS-1:0][ENT_W-1:0]           dcnt;
        logic                                     halt;
        logic                                     win;
        ttf_div_type                              dst;
        logic [4:0]                               dcyc;
        logic [DIV_W-1:0]                         num;
        logic [DIV_W-1:0]                         quo;
        logic [DIV_W-1:0]                         period;
        logic [MHZ_W-1:0]                         mhz;
        logic [MHZ_W-1:0]                         rem;
        logic [TIME_W-1:0]                        now;
        logic                                     fv;
        logic [ADDR_W-1:0]                        fa;
        logic [DATA_W-1:0]                        fd;
        logic [TAG_W-1:0]                         ft;
        logic [SRC_W-1:0]                         fs;
        logic [TIME_W-1:0]                        ftm;
    } ttf_state_type;

    ttf_state_type         st_r;
    ttf_state_type         st_nxt;
    logic [BUS_DW-1:0]     rdv;
    logic [BUS_DW-1:0]     bm;
    logic [BUS_DW-1:0]     wd;
    logic [ENT_W-1:0]      qs_ent;
    logic [1:0]            qs_set;
    logic                  qs_lst;
    logic                  sel_ok;
    logic [1:0]            pset;
    logic                  page;
    logic                  wr_take;
    logic                  qual;
    logic [NUM_SETS-1:0]   set_and;
    logic [NUM_SETS-1:0]   set_or;
    logic [NUM_TRIG-1:0]   fire;
    logic                  any_fire;
    logic                  filt_hit;
    logic                  cap;
    logic [MHZ_W:0]        trial;
    logic [MHZ_W:0]        diff;
    logic                  qbit;
    logic [ENT_W-1:0]      wcnt_a;
    logic [ENT_W-1:0]      wcnt_d;

    // only executed fetches and real data accesses count
    // every source bus feeds the same comparators
    assign qual = cyc_valid_i && cyc_exec_i;

    // per-set comparators against every stored qualifier entry
    genvar g;
    generate
        for (g = 0; g < NUM_SETS; g++) begin : g_set
            logic ah;
            logic dh;
            // masked range compare over up to 50 entries
            always_comb begin
                ah = 1'b0;
                dh = 1'b0;
                for (int e = 0; e < NUM_ENT; e++) begin
                    if (ENT_W'(e) < st_r.acnt[g]
                        && (cyc_addr_i & st_r.amask[g]) >= (st_r.alo[g][e] & st_r.amask[g])
                        && (cyc_addr_i & st_r.amask[g]) <= (st_r.ahi[g][e] & st_r.amask[g])) begin
                        ah = 1'b1;
                    end
                    if (ENT_W'(e) < st_r.dcnt[g]
                        && (cyc_data_i & st_r.dmask[g]) >= (st_r.dlo[g][e] & st_r.dmask[g])
                        && (cyc_data_i & st_r.dmask[g]) <= (st_r.dhi[g][e] & st_r.dmask[g])) begin
                        dh = 1'b1;
                    end
                end
            end
            // an empty list imposes nothing, a filled one must hit; a set with both lists empty never fires
            assign set_and[g] = qual && (st_r.acnt[g] != '0 || st_r.dcnt[g] != '0)
                                && (ah || st_r.acnt[g] == '0) && (dh || st_r.dcnt[g] == '0);
            // filter set in normal mode takes either qualifier
            assign set_or[g]  = qual && (ah || dh);
        end
    endgenerate

    // three triggers, each gated by its own enable
    assign fire     = set_and[NUM_TRIG-1:0] & st_r.ctrl[CB_TEN +: NUM_TRIG];
    assign any_fire = |fire;
    assign filt_hit = set_or[FILT_SET];

    // capture gate: all, normal filter, or window
    assign cap = qual && st_r.ctrl[CB_TRACE]
                 && (!st_r.ctrl[CB_FILT]
                     || (st_r.ctrl[CB_WIN] ? (st_r.win || fire[0]) : filt_hit));

    // register decode helpers
    assign qs_ent  = st_r.qsel[QS_ENT +: ENT_W];
    assign qs_lst  = st_r.qsel[QS_LIST];
    assign qs_set  = st_r.qsel[QS_SET +: 2];
    assign sel_ok  = qs_ent < ENT_MAX;
    assign pset    = address_i[3:2];
    assign page    = address_i[7:4] == SET_PAGE;
    assign wr_take = write_i && !st_r.wreq;
    assign bm      = {{8{byteenable_i[3]}}, {8{byteenable_i[2]}}, {8{byteenable_i[1]}}, {8{byteenable_i[0]}}};
    // byte lanes merge into the current value so partial writes keep the rest
    assign wd      = (rdv & ~bm) | (writedata_i & bm);
    assign wcnt_a  = (wd[ENT_W-1:0] > ENT_MAX) ? ENT_MAX : wd[ENT_W-1:0];
    assign wcnt_d  = (wd[CNT_D +: ENT_W] > ENT_MAX) ? ENT_MAX : wd[CNT_D +: ENT_W];

    // read mux of the housekeeping register port
    always_comb begin
        rdv = RD_NONE;
        case (address_i)
            REG_CTRL:   rdv = BUS_DW'(st_r.ctrl);
            REG_STATUS: begin
                rdv[ST_HALT] = st_r.halt;
                rdv[ST_REC]  = st_r.ctrl[CB_TRACE];
                rdv[ST_WIN]  = st_r.win;
                rdv[ST_DIV]  = st_r.dst == DIV_RUN;
            end
            REG_QSEL:   rdv = BUS_DW'(st_r.qsel);
            REG_QLO: begin
                if (sel_ok) begin
                    rdv = qs_lst ? BUS_DW'(st_r.dlo[qs_set][qs_ent]) : BUS_DW'(st_r.alo[qs_set][qs_ent]);
                end
            end
            REG_QHI: begin
                if (sel_ok) begin
                    rdv = qs_lst ? BUS_DW'(st_r.dhi[qs_set][qs_ent]) : BUS_DW'(st_r.ahi[qs_set][qs_ent]);
                end
            end
            REG_CLK:    rdv = BUS_DW'(st_r.mhz);
            REG_PERIOD: rdv = BUS_DW'(st_r.period);
            default: begin
                if (page) begin
                    case (address_i[1:0])
                        FLD_AMASK: rdv = BUS_DW'(st_r.amask[pset]);
                        FLD_DMASK: rdv = BUS_DW'(st_r.dmask[pset]);
                        FLD_CNT: begin
                            rdv[ENT_W-1:0]      = st_r.acnt[pset];
                            rdv[CNT_D +: ENT_W] = st_r.dcnt[pset];
                        end
                        default: rdv = RD_NONE;
                    endcase
                end
            end
        endcase
    end

    // next state: divider, bus writes, then hardware events so they win over same-cycle writes
    always_comb begin
        st_nxt = st_r;
        trial  = {st_r.rem, st_r.num[DIV_W-1]};
        diff   = trial - {1'b0, st_r.mhz};
        qbit   = trial >= {1'b0, st_r.mhz};
        // restoring divider turns mhz into a picosecond tick period
        case (st_r.dst)
            DIV_RUN: begin
                if (qbit) begin
                    st_nxt.rem = diff[MHZ_W-1:0];
                end else begin
                    st_nxt.rem = trial[MHZ_W-1:0];
                end
                st_nxt.quo  = {st_r.quo[DIV_W-2:0], qbit};
                st_nxt.num  = {st_r.num[DIV_W-2:0], 1'b0};
                st_nxt.dcyc = st_r.dcyc + 5'h1;
                if (st_r.mhz == '0) begin
                    st_nxt.dst    = DIV_IDLE;
                    st_nxt.period = '0;
                end else if (st_r.dcyc == DIV_LAST) begin
                    st_nxt.dst    = DIV_IDLE;
                    st_nxt.period = {st_r.quo[DIV_W-2:0], qbit};
                end
            end
            default: ;
        endcase
        // one wait cycle, then the answer stands for one cycle
        if ((read_i || write_i) && st_r.wreq) begin
            st_nxt.wreq  = 1'b0;
            st_nxt.rdata = rdv;
        end else begin
            st_nxt.wreq  = 1'b1;
        end
        if (wr_take) begin
            case (address_i)
                REG_CTRL:   st_nxt.ctrl = wd[CTRL_W-1:0];
                REG_STATUS: begin
                    if (wd[ST_HALT]) begin
                        st_nxt.halt = 1'b0;
                    end
                end
                REG_QSEL:   st_nxt.qsel = wd[QSEL_W-1:0];
                REG_QLO: begin
                    if (sel_ok && qs_lst) begin
                        st_nxt.dlo[qs_set][qs_ent] = wd[DATA_W-1:0];
                    end else if (sel_ok) begin
                        st_nxt.alo[qs_set][qs_ent] = wd[ADDR_W-1:0];
                    end
                end
                REG_QHI: begin
                    if (sel_ok && qs_lst) begin
                        st_nxt.dhi[qs_set][qs_ent] = wd[DATA_W-1:0];
                    end else if (sel_ok) begin
                        st_nxt.ahi[qs_set][qs_ent] = wd[ADDR_W-1:0];
                    end
                end
                REG_CLK: begin
                    st_nxt.mhz  = wd[MHZ_W-1:0];
                    st_nxt.dst  = DIV_RUN;
                    st_nxt.num  = PS_PER_US;
                    st_nxt.rem  = '0;
                    st_nxt.quo  = '0;
                    st_nxt.dcyc = '0;
                end
                default: begin
                    if (page && address_i[1:0] == FLD_AMASK) begin
                        st_nxt.amask[pset] = wd[ADDR_W-1:0];
                    end else if (page && address_i[1:0] == FLD_DMASK) begin
                        st_nxt.dmask[pset] = wd[DATA_W-1:0];
                    end else if (page && address_i[1:0] == FLD_CNT) begin
                        st_nxt.acnt[pset] = wcnt_a;
                        st_nxt.dcnt[pset] = wcnt_d;
                    end
                end
            endcase
        end
        // free-running target time base
        if (cpu_tick_i) begin
            st_nxt.now = st_r.now + TIME_W'(st_r.period);
        end
        // frame with tag, source bus and timestamp
        st_nxt.fv = cap;
        if (cap) begin
            st_nxt.fa  = cyc_addr_i;
            st_nxt.fd  = cyc_data_i;
            st_nxt.fs  = cyc_src_i;
            st_nxt.ftm = st_r.now;
            st_nxt.ft  = {cyc_kind_i, cyc_size_i};
            if (cyc_size_i == SIZE_2 && (cyc_kind_i == KIND_FETCH || cyc_kind_i == KIND_FLUSH)) begin
                st_nxt.ft = TWO_BYTE_FETCH_TAG;
            end
        end
        // window opens on trigger one, closes on trigger two
        if (fire[0]) begin
            st_nxt.win = 1'b1;
        end else if (fire[1]) begin
            st_nxt.win = 1'b0;
        end
        // trigger may stop trace; host restarts it to reload
        if (any_fire && st_r.ctrl[CB_STOP]) begin
            st_nxt.ctrl[CB_TRACE] = 1'b0;
        end
        // halt wins over a same-cycle clear; config alone never halts
        if (any_fire && st_r.ctrl[CB_BREAK]) begin
            st_nxt.halt = 1'b1;
        end
        // window never outlives recording
        if (!st_nxt.ctrl[CB_TRACE]) begin
            st_nxt.win = 1'b0;
        end
    end

    // state register, synchronous reset
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            st_r        <= '0;
            st_r.wreq   <= 1'b1;
            st_r.amask  <= '1;
            st_r.dmask  <= '1;
            st_r.mhz    <= DEF_MHZ;
            st_r.period <= DEF_PERIOD;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state register
    assign readdata_o    = st_r.rdata;
    assign waitrequest_o = st_r.wreq;
    assign halt_o        = st_r.halt;
    assign recording_o   = st_r.ctrl[CB_TRACE];
    assign shadow_en_o   = st_r.ctrl[CB_TRACE];
    assign frame_valid_o = st_r.fv;
    assign frame_addr_o  = st_r.fa;
    assign frame_data_o  = st_r.fd;
    assign frame_tag_o   = st_r.ft;
    assign frame_src_o   = st_r.fs;
    assign frame_time_o  = st_r.ftm;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_req_waiting;
        (read_i || write_i) && waitrequest_o;
    endsequence
    sequence s_answered;
        !waitrequest_o;
    endsequence
    sequence s_window_start;
        st_r.ctrl[CB_FILT] && st_r.ctrl[CB_WIN] && st_r.ctrl[CB_TRACE] && fire[0];
    endsequence

    chk_bus_answer_time: assert property (s_req_waiting |=> s_answered)
        else $error("register request not answered after one wait cycle");
    chk_halt_on_fire: assert property (st_r.ctrl[CB_BREAK] && any_fire |=> halt_o)
        else $error("enabled trigger did not halt emulation");
    chk_no_spurious_halt: assert property (!halt_o && !any_fire |=> !halt_o)
        else $error("halt raised without a trigger");
    chk_disabled_trig_quiet: assert property (st_r.ctrl[CB_TEN +: NUM_TRIG] == '0 && !halt_o |=> !halt_o)
        else $error("disabled trigger fired");
    chk_prefetch_dropped: assert property (cyc_valid_i && !cyc_exec_i |=> !frame_valid_o)
        else $error("discarded prefetch captured");
    chk_filter_gate_normal: assert property (st_r.ctrl[CB_FILT] && !st_r.ctrl[CB_WIN] && !filt_hit
                                             |=> !frame_valid_o)
        else $error("non-qualifying cycle recorded");
    chk_window_opens: assert property (s_window_start ##1 1'b1 |-> frame_valid_o)
        else $error("window start cycle not recorded");
    chk_write_tag_code: assert property (cap && cyc_kind_i == KIND_WRITE && cyc_size_i == SIZE_1
                                         |=> frame_tag_o == ONE_BYTE_WRITE_TAG)
        else $error("one-byte write tag wrong");
    chk_fetch_tag_code: assert property (cap && cyc_size_i == SIZE_2 && cyc_kind_i == KIND_FLUSH
                                         |=> frame_tag_o == TWO_BYTE_FETCH_TAG)
        else $error("two-byte flush tag wrong");
    chk_trace_stop_trig: assert property (st_r.ctrl[CB_STOP] && any_fire |=> !recording_o)
        else $error("trigger did not stop trace");
    chk_shadow_follows: assert property (shadow_en_o == recording_o)
        else $error("shadow update not tied to recording");
endmodule
`default_nettype wire

//--- ttf_cpu_model.sv
// bus-cycle model of the emulated cpu and its bondout buses
// assumes one request pulse from the bench for each cycle wanted
`timescale 1ns/1ps
`default_nettype none
module ttf_cpu_model (
    input  wire logic        clk_i,
    input  wire logic        req_i,
    input  wire logic [6:0]  ctl_i,
    input  wire logic [23:0] addr_i,
    input  wire logic [15:0] data_i,
    output logic             tick_o,
    output logic             valid_o,
    output logic             exec_o,
    output logic [1:0]       src_o,
    output logic [1:0]       kind_o,
    output logic [1:0]       size_o,
    output logic [23:0]      addr_o,
    output logic [15:0]      data_o
);
    logic [47:0] st_r   = 48'h0;
    logic [2:0]  div_r  = 3'h0;
    assign {valid_o, exec_o, src_o, kind_o, size_o, addr_o, data_o} = st_r;
    assign tick_o = (div_r == 3'h0);
    // exec flag and bus source sent per cycle; idle bus shows inverse of last value
    always_ff @(posedge clk_i) begin
        div_r <= div_r + 3'h1;
        st_r  <= req_i ? {1'b1, ctl_i, addr_i, data_i} : {8'h00, ~st_r[39:0]};
    end
endmodule
`default_nettype wire

//--- ttf_trace_unit_tb_top.sv
// self-checking bench for the trace capture and trigger unit
// assumes the cpu model drives the bus-cycle inputs, bench drives avalon
`timescale 1ns/1ps
`default_nettype none
module ttf_trace_unit_tb_top;
    import ttf_pkg::*;
    logic clk_i = 1'b0, rst_b = 1'b0, read = 1'b0, write = 1'b0, req = 1'b0;
    logic [7:0]  address = 8'h0;
    logic [31:0] wdata = 32'h0, rdata, q;
    logic [6:0]  ctl = 7'h0;
    logic [23:0] cadr = 24'h0, f_addr, c_addr;
    logic [15:0] cdat = 16'h0, f_data, c_data;
    logic [47:0] f_time, f0;
    logic [3:0]  f_tag;
    logic [1:0]  f_src, c_src, c_kind, c_size;
    logic wait_r, tick, c_valid, c_exec, halt, rec, shadow, fv;
    int err_count = 0, tests_run = 0;
    initial forever #4 clk_i = ~clk_i;
    ttf_cpu_model i_cpu (.clk_i(clk_i), .req_i(req), .ctl_i(ctl), .addr_i(cadr), .data_i(cdat), .tick_o(tick),
        .valid_o(c_valid), .exec_o(c_exec), .src_o(c_src), .kind_o(c_kind), .size_o(c_size), .addr_o(c_addr),
        .data_o(c_data));
    ttf_trace_unit i_dut (.clk_i(clk_i), .rst_b_i(rst_b), .address_i(address), .read_i(read), .write_i(write),
        .writedata_i(wdata), .byteenable_i(4'hf), .readdata_o(rdata), .waitrequest_o(wait_r), .cpu_tick_i(tick),
        .cyc_valid_i(c_valid), .cyc_exec_i(c_exec), .cyc_src_i(c_src), .cyc_kind_i(c_kind), .cyc_size_i(c_size),
        .cyc_addr_i(c_addr), .cyc_data_i(c_data), .halt_o(halt), .recording_o(rec), .shadow_en_o(shadow),
        .frame_valid_o(fv), .frame_addr_o(f_addr), .frame_data_o(f_data), .frame_tag_o(f_tag),
        .frame_src_o(f_src), .frame_time_o(f_time));
    task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // request held until waitrequest is sampled low, read data taken at that edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        address <= a; wdata <= d; write <= wr; read <= !wr;
        @(posedge clk_i);
        while (wait_r !== 1'b0) @(posedge clk_i);
        q = rdata;
        read <= 1'b0; write <= 1'b0;
    endtask
    // one bus cycle from the cpu model, frame presence judged one cycle after it
    task automatic send(input logic [6:0] c, input logic [23:0] a, input logic [15:0] d, input logic e);
        @(posedge clk_i);
        req <= 1'b1; ctl <= c; cadr <= a; cdat <= d;
        @(posedge clk_i);
        req <= 1'b0;
        @(posedge clk_i);
        #1;
        chk("frame_valid", fv, e);
    endtask
    // one address entry and one data entry, data mask 00ff, both counts one
    task automatic cfg(input logic [1:0] s, input logic [23:0] a);
        bus(1, REG_QSEL, {22'h0, s, 8'h00});
        bus(1, REG_QLO, {8'h0, a});
        bus(1, REG_QHI, {8'h0, a});
        bus(1, REG_QSEL, {22'h0, s, 8'h40});
        bus(1, REG_QLO, 32'h34);
        bus(1, REG_QHI, 32'h34);
        bus(1, {SET_PAGE, s, FLD_DMASK}, 32'h00ff);
        bus(1, {SET_PAGE, s, FLD_CNT}, 32'h00010001);
    endtask
    task automatic t_reset();
        chk("halt", halt, 1'b0);
        chk("recording", rec, 1'b0);
        bus(0, REG_PERIOD, 32'h0);
        chk("period", q, {12'h0, DEF_PERIOD});
        bus(0, 8'h3f, 32'h0);
        chk("unmapped", q, RD_NONE);
        // last legal entry stores, entry fifty is refused
        bus(1, REG_QSEL, 32'h31);
        bus(1, REG_QLO, 32'h123);
        bus(0, REG_QLO, 32'h0);
        chk("entry49", q, 32'h123);
        bus(1, REG_QSEL, 32'h32);
        bus(1, REG_QLO, 32'h5a);
        bus(0, REG_QLO, 32'h0);
        chk("entry50", q, RD_NONE);
        bus(1, REG_CLK, 32'd40);
        repeat (40) bus(0, REG_STATUS, 32'h0);
        bus(0, REG_PERIOD, 32'h0);
        chk("period40", q, 32'd25000);
        $display("done t_reset");
    endtask
    task automatic t_trig();
        cfg(2'h0, 24'h005017);
        bus(1, REG_CTRL, 32'h27);
        send(7'h49, 24'h005017, 16'h0035, 1'b1);
        chk("halt data miss", halt, 1'b0);
        send(7'h12, 24'h005017, 16'h0034, 1'b0);
        chk("halt prefetch", halt, 1'b0);
        send(7'h52, 24'h000470, 16'h3c00, 1'b1);
        chk("fetch tag", f_tag, TWO_BYTE_FETCH_TAG);
        chk("fetch src", f_src, SRC_INTERNAL_INSTR_BUS);
        send(7'h5e, 24'h000472, 16'h0000, 1'b1);
        chk("flush tag", f_tag, TWO_BYTE_FETCH_TAG);
        send(7'h49, 24'h005017, 16'h1234, 1'b1);
        chk("write tag", f_tag, ONE_BYTE_WRITE_TAG);
        chk("write data", f_data, 16'h1234);
        chk("halt", halt, 1'b1);
        chk("stop trace", rec, 1'b0);
        chk("shadow", shadow, 1'b0);
        $display("done t_trig");
    endtask
    task automatic t_dis();
        bus(1, REG_STATUS, 32'h1);
        bus(1, REG_CTRL, 32'h03);
        send(7'h49, 24'h005017, 16'h0034, 1'b1);
        chk("disabled", halt, 1'b0);
        bus(1, REG_CTRL, 32'h00);
        send(7'h49, 24'h005017, 16'h0034, 1'b0);
        $display("done t_dis");
    endtask
    task automatic t_filt();
        cfg(2'h3, 24'h005017);
        bus(1, REG_CTRL, 32'h09);
        send(7'h52, 24'h000470, 16'h0000, 1'b0);
        send(7'h49, 24'h005017, 16'h0034, 1'b1);
        chk("filter addr", f_addr, 24'h005017);
        // captures eight clocks apart see exactly one cpu tick of 25000 ps
        f0 = f_time;
        repeat (5) @(posedge clk_i);
        send(7'h65, 24'h000472, 16'h0034, 1'b1);
        chk("filter data", f_addr, 24'h000472);
        chk("filter data val", f_data, 16'h0034);
        chk("filter src", f_src, SRC_INTERNAL_OPERAND_BUS);
        chk("stamp step", f_time - f0, 48'd25000);
        bus(1, {SET_PAGE, 2'h3, FLD_AMASK}, 32'hfff0ff);
        send(7'h49, 24'h005a17, 16'h0000, 1'b1);
        chk("masked addr", f_addr, 24'h005a17);
        $display("done t_filt");
    endtask
    task automatic t_win();
        cfg(2'h1, 24'h000480);
        bus(1, REG_CTRL, 32'h00);
        bus(1, REG_CTRL, 32'h79);
        send(7'h52, 24'h000470, 16'h0000, 1'b0);
        send(7'h49, 24'h005017, 16'h0034, 1'b1);
        send(7'h52, 24'h000470, 16'h0000, 1'b1);
        chk("inside window", f_addr, 24'h000470);
        send(7'h49, 24'h000480, 16'h0034, 1'b1);
        send(7'h52, 24'h000470, 16'h0000, 1'b0);
        chk("no halt", halt, 1'b0);
        $display("done t_win");
    endtask
    task automatic test_done();
        $display("tests %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk_i);
        rst_b <= 1'b1;
        @(posedge clk_i);
        t_reset();
        t_trig();
        t_dis();
        t_filt();
        t_win();
        test_done();
    end
    // hang guard, well beyond the few hundred cycles the tests need
    initial begin
        #200000;
        err_count++;
        test_done();
    end
endmodule
`default_nettype wire
